// *** cap_pkg.sv ***
// shared constants, slot types and slot helpers for the audio port ends
package cap_pkg;

	// ********************************************
	// sample layout and formats
	// ********************************************
	localparam int SAMPLE_W = 20;
	localparam int SHORT_W = 16;
	localparam int SHORT_PAD = 4;
	localparam logic [1:0] FMT_LJ20_RJ16 = 2'h0;
	localparam logic [1:0] FMT_LJ20_RJ20 = 2'h1;
	localparam logic [1:0] FMT_LJ20_LJ20 = 2'h2;
	localparam logic [1:0] FMT_I2S = 2'h3;

	typedef enum logic [2:0] {
		SLOT_MSB20,
		SLOT_LSB16,
		SLOT_LSB20,
		SLOT_I2S20,
		SLOT_I2S16
	} cap_slot_t;

	// ********************************************
	// device timing and filter
	// ********************************************
	localparam int INIT_FRAMES = 4128;
	localparam int INIT_CNT_W = 13;
	localparam int HPF_SHIFT = 11;
	localparam int ACC_W = 34;
	localparam logic signed [ACC_W-1:0] SAMPLE_MAX = 34'sh0007FFFF;
	localparam logic signed [ACC_W-1:0] SAMPLE_MIN = -34'sh00080000;
	localparam logic [10:0] MCLK_384_MIN = 11'h140;
	localparam logic [10:0] INT_TICKS = 11'h100;
	localparam logic [7:0] BCLK_32FS = 8'h20;
	localparam logic [5:0] POS_MAX = 6'h3F;

	// ********************************************
	// controller clock generation
	// ********************************************
	localparam logic [4:0] BCLK_HALF = 5'h10;
	localparam logic [5:0] HALF_BITS = 6'h18;
	localparam logic [5:0] FRAME_BITS = 6'h30;
	localparam logic [2:0] MCLK_HALF_256 = 3'h3;
	localparam logic [2:0] MCLK_HALF_384 = 3'h2;

	// ********************************************
	// controller registers
	// ********************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
	localparam logic [7:0] REG_TX_LEFT = 8'h10;
	localparam logic [7:0] REG_TX_RIGHT = 8'h14;
	localparam logic [7:0] REG_RX_LEFT = 8'h18;
	localparam logic [7:0] REG_RX_RIGHT = 8'h1C;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_RELEASE = 1;
	localparam int CTRL_MCLK384 = 2;
	localparam int CTRL_FMT_LSB = 4;
	localparam int IRQ_FRAME = 0;
	localparam int IRQ_MISMATCH = 1;
	localparam logic [5:0] CTRL_RESET = 6'h00;

	// ********************************************
	// slot helpers
	// ********************************************
	function automatic cap_slot_t cap_capture_slot(input logic [1:0] fmt, input logic is32);
		if (fmt == FMT_I2S)
			cap_capture_slot = is32 ? SLOT_I2S16 : SLOT_I2S20;
		else
			cap_capture_slot = SLOT_MSB20;
	endfunction

	function automatic cap_slot_t cap_playback_slot(input logic [1:0] fmt, input logic is32);
		case (fmt)
			FMT_LJ20_RJ16: cap_playback_slot = SLOT_LSB16;
			FMT_LJ20_RJ20: cap_playback_slot = SLOT_LSB20;
			FMT_LJ20_LJ20: cap_playback_slot = SLOT_MSB20;
			default: cap_playback_slot = is32 ? SLOT_I2S16 : SLOT_I2S20;
		endcase
	endfunction

	// bit sent at slot position p of a half of length half
	function automatic logic cap_slot_bit(input logic [19:0] w, input logic [5:0] p,
		input cap_slot_t s, input logic [5:0] half);
		logic [5:0] i;
		i = 6'h00;
		cap_slot_bit = 1'b0;
		case (s)
			SLOT_MSB20: if (p < 6'h14) cap_slot_bit = w[5'h13 - p[4:0]];
			SLOT_LSB20: begin
				i = half - 6'h01 - p;
				if (i < 6'h14) cap_slot_bit = w[i[4:0]];
			end
			SLOT_LSB16: begin
				i = half - 6'h01 - p;
				if (i < 6'h10) cap_slot_bit = w[i[4:0] + 5'h04];
			end
			SLOT_I2S20: begin
				i = p - 6'h01;
				if (p != 6'h00 && i < 6'h14) cap_slot_bit = w[5'h13 - i[4:0]];
			end
			default: begin
				i = p - 6'h01;
				if (p != 6'h00 && i < 6'h10) cap_slot_bit = w[5'h13 - i[4:0]];
			end
		endcase
	endfunction

	function automatic logic cap_slot_take(input logic [5:0] p, input cap_slot_t s);
		case (s)
			SLOT_MSB20: cap_slot_take = p < 6'h14;
			SLOT_I2S20: cap_slot_take = p != 6'h00 && p <= 6'h14;
			SLOT_I2S16: cap_slot_take = p != 6'h00 && p <= 6'h10;
			default: cap_slot_take = 1'b1;
		endcase
	endfunction

	function automatic logic [19:0] cap_slot_word(input logic [19:0] sr, input cap_slot_t s);
		if (s == SLOT_LSB16 || s == SLOT_I2S16)
			cap_slot_word = {sr[SHORT_W-1:0], {SHORT_PAD{1'b0}}};
		else
			cap_slot_word = sr;
	endfunction

	function automatic logic cap_is_left(input logic [1:0] fmt, input logic frame_level);
		cap_is_left = (fmt == FMT_I2S) ? ~frame_level : frame_level;
	endfunction

endpackage

// *** cap_link_if.sv ***
// serial audio link between the codec end and the audio controller end
`timescale 1ns/10ps
interface cap_link_if;
	logic master_clk;
	logic bit_clk;
	logic frame_sync_clk;
	logic powerdown_n;
	logic playback_serial_in;
	logic capture_serial_out_a;
	logic capture_serial_out_b;

	modport device (
		input  master_clk,
		input  bit_clk,
		input  frame_sync_clk,
		input  powerdown_n,
		input  playback_serial_in,
		output capture_serial_out_a,
		output capture_serial_out_b
	);

	modport host (
		output master_clk,
		output bit_clk,
		output frame_sync_clk,
		output powerdown_n,
		output playback_serial_in,
		input  capture_serial_out_a,
		input  capture_serial_out_b
	);
endinterface

// *** cap_codec_end.sv ***
// codec end: clock intake, init cycle, capture high-pass and serial audio port
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module cap_codec_end #(
	parameter int INIT_FRAMES = cap_pkg::INIT_FRAMES
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	cap_link_if.device       link,
	input  wire logic [3:0]  power_manage_bits,
	input  wire logic [1:0]  format_select,
	input  wire logic        capture_out_b_mute,
	input  wire logic [19:0] adc_left,
	input  wire logic [19:0] adc_right,
	output logic      [19:0] playback_left,
	output logic      [19:0] playback_right,
	output logic             playback_valid,
	output logic             init_done,
	output logic             input_gain_amp_mute,
	output logic             mclk_is_384,
	output logic             mclk_locked,
	output logic             bclk_is_32fs
);

	// ********************************************
	// filter helpers
	// ********************************************
	function automatic logic [cap_pkg::ACC_W-1:0] hpf_step(input logic [19:0] x, input logic [19:0] xp,
		input logic [cap_pkg::ACC_W-1:0] acc);
		logic signed [cap_pkg::ACC_W-1:0] d;
		d = (cap_pkg::ACC_W'(signed'(x)) - cap_pkg::ACC_W'(signed'(xp))) <<< cap_pkg::HPF_SHIFT;
		hpf_step = acc + d - cap_pkg::ACC_W'(signed'(acc) >>> cap_pkg::HPF_SHIFT);
	endfunction

	function automatic logic [19:0] hpf_out(input logic [cap_pkg::ACC_W-1:0] acc);
		logic signed [cap_pkg::ACC_W-1:0] y;
		y = signed'(acc) >>> cap_pkg::HPF_SHIFT;
		if (y > cap_pkg::SAMPLE_MAX)
			hpf_out = cap_pkg::SAMPLE_MAX[19:0];
		else if (y < cap_pkg::SAMPLE_MIN)
			hpf_out = cap_pkg::SAMPLE_MIN[19:0];
		else
			hpf_out = y[19:0];
	endfunction

	// ********************************************
	// pin synchronisers
	// ********************************************
	// bit 4 data in, 3 master, 2 bit clock, 1 frame sync, 0 powerdown
	logic [4:0] pin_s1;
	logic [4:0] pin_s2;
	logic [4:0] pin_s3;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1 <= 5'h00;
			pin_s2 <= 5'h00;
			pin_s3 <= 5'h00;
		end else begin
			pin_s1 <= {link.playback_serial_in, link.master_clk, link.bit_clk,
				link.frame_sync_clk, link.powerdown_n};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	logic             mclk_rise;
	logic             bclk_rise;
	logic             bclk_fall;
	logic             frame_lvl;
	logic             dev_off;
	logic             frame_sync_clk_half;
	logic             half_start;
	logic             left_now;
	logic             left_start;
	logic             right_start;
	logic [5:0]       pos;
	logic [5:0]       next_pos;
	logic [5:0]       half_len;
	cap_pkg::cap_slot_t cap_slot;
	cap_pkg::cap_slot_t pb_slot;

	assign mclk_rise = pin_s2[3] & ~pin_s3[3];
	assign bclk_rise = pin_s2[2] & ~pin_s3[2];
	assign bclk_fall = ~pin_s2[2] & pin_s3[2];
	assign frame_lvl = pin_s2[1];
	// powerdown pin or all power bits clear
	assign dev_off = ~pin_s2[0] | (power_manage_bits == 4'h0);
	assign half_start = bclk_fall & (frame_lvl != frame_sync_clk_half);
	assign left_now = cap_pkg::cap_is_left(format_select, frame_lvl);
	assign left_start = half_start & left_now;
	assign right_start = half_start & ~left_now;
	assign next_pos = half_start ? 6'h00 : ((pos == cap_pkg::POS_MAX) ? pos : pos + 6'h01);
	assign cap_slot = cap_pkg::cap_capture_slot(format_select, bclk_is_32fs);
	assign pb_slot = cap_pkg::cap_playback_slot(format_select, bclk_is_32fs);

	// ********************************************
	// slot position within each half frame
	// ********************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos <= 6'h00;
			frame_sync_clk_half <= 1'b0;
			half_len <= 6'h00;
		end else if (dev_off) begin
			pos <= 6'h00;
			frame_sync_clk_half <= 1'b0;
			half_len <= 6'h00;
		end else if (bclk_fall) begin
			frame_sync_clk_half <= frame_lvl;
			pos <= next_pos;
			if (half_start)
				half_len <= pos + 6'h01;
		end
	end

	// ********************************************
	// clock rate detection
	// ********************************************
	logic [10:0] mclk_cnt;
	logic [10:0] tick_cnt;
	logic [7:0]  bclk_cnt;
	logic [1:0]  mod3;
	logic        int_tick;

	// drop every third master edge at 384fs
	assign int_tick = mclk_rise & (~mclk_is_384 | (mod3 != 2'h2));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mclk_cnt <= 11'h000;
			tick_cnt <= 11'h000;
			bclk_cnt <= 8'h00;
			mod3 <= 2'h0;
			mclk_is_384 <= 1'b0;
			mclk_locked <= 1'b0;
			bclk_is_32fs <= 1'b0;
		end else if (dev_off) begin
			mclk_cnt <= 11'h000;
			tick_cnt <= 11'h000;
			bclk_cnt <= 8'h00;
			mod3 <= 2'h0;
			mclk_is_384 <= 1'b0;
			mclk_locked <= 1'b0;
			bclk_is_32fs <= 1'b0;
		end else if (left_start) begin
			mclk_is_384 <= mclk_cnt >= cap_pkg::MCLK_384_MIN;
			mclk_locked <= tick_cnt == cap_pkg::INT_TICKS;
			bclk_is_32fs <= bclk_cnt == cap_pkg::BCLK_32FS;
			// an edge on the frame boundary opens the next count
			mclk_cnt <= {10'h000, mclk_rise};
			tick_cnt <= {10'h000, int_tick};
			bclk_cnt <= 8'h01;
			if (mclk_rise)
				mod3 <= (mod3 == 2'h2) ? 2'h0 : mod3 + 2'h1;
		end else begin
			if (mclk_rise) begin
				mclk_cnt <= mclk_cnt + 11'h001;
				mod3 <= (mod3 == 2'h2) ? 2'h0 : mod3 + 2'h1;
			end
			if (int_tick)
				tick_cnt <= tick_cnt + 11'h001;
			if (bclk_fall)
				bclk_cnt <= bclk_cnt + 8'h01;
		end
	end

	// ********************************************
	// initialization cycle
	// ********************************************
	logic [cap_pkg::INIT_CNT_W-1:0] frame_cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_cnt <= '0;
			init_done <= 1'b0;
		end else if (dev_off) begin
			frame_cnt <= '0;
			init_done <= 1'b0;
		end else if (left_start && !init_done) begin
			frame_cnt <= frame_cnt + 1'b1;
			if (frame_cnt == cap_pkg::INIT_CNT_W'(INIT_FRAMES - 1))
				init_done <= 1'b1;
		end
	end

	assign input_gain_amp_mute = ~init_done;

	// ********************************************
	// capture high-pass filter
	// ********************************************
	logic [cap_pkg::ACC_W-1:0] acc_l;
	logic [cap_pkg::ACC_W-1:0] acc_r;
	logic [19:0]               xp_l;
	logic [19:0]               xp_r;
	logic [19:0]               cap_l;
	logic [19:0]               cap_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_l <= '0;
			acc_r <= '0;
			xp_l <= 20'h00000;
			xp_r <= 20'h00000;
			cap_l <= 20'h00000;
			cap_r <= 20'h00000;
		end else if (dev_off) begin
			acc_l <= '0;
			acc_r <= '0;
			xp_l <= 20'h00000;
			xp_r <= 20'h00000;
			cap_l <= 20'h00000;
			cap_r <= 20'h00000;
		end else if (right_start) begin
			acc_l <= hpf_step(adc_left, xp_l, acc_l);
			acc_r <= hpf_step(adc_right, xp_r, acc_r);
			xp_l <= adc_left;
			xp_r <= adc_right;
			cap_l <= init_done ? hpf_out(acc_l) : 20'h00000;
			cap_r <= init_done ? hpf_out(acc_r) : 20'h00000;
		end
	end

	// ********************************************
	// capture serial lines
	// ********************************************
	logic out_bit;
	logic sdo_a;
	logic sdo_b;

	assign out_bit = cap_pkg::cap_slot_bit(left_now ? cap_l : cap_r, next_pos, cap_slot, half_len);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sdo_a <= 1'b0;
			sdo_b <= 1'b0;
		end else if (dev_off) begin
			sdo_a <= 1'b0;
			sdo_b <= 1'b0;
		end else if (bclk_fall) begin
			sdo_a <= out_bit;
			sdo_b <= out_bit & ~capture_out_b_mute;
		end else begin
			// mute acts at once, not at the next bit
			sdo_b <= sdo_a & ~capture_out_b_mute;
		end
	end

	assign link.capture_serial_out_a = sdo_a;
	assign link.capture_serial_out_b = sdo_b;

	// ********************************************
	// playback receiver
	// ********************************************
	logic [19:0] pb_sr;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pb_sr <= 20'h00000;
			playback_left <= 20'h00000;
			playback_right <= 20'h00000;
			playback_valid <= 1'b0;
		end else if (dev_off) begin
			pb_sr <= 20'h00000;
			playback_left <= 20'h00000;
			playback_right <= 20'h00000;
			playback_valid <= 1'b0;
		end else begin
			playback_valid <= 1'b0;
			if (half_start) begin
				pb_sr <= 20'h00000;
				if (cap_pkg::cap_is_left(format_select, frame_sync_clk_half)) begin
					playback_left <= cap_pkg::cap_slot_word(pb_sr, pb_slot);
				end else begin
					playback_right <= cap_pkg::cap_slot_word(pb_sr, pb_slot);
					playback_valid <= 1'b1;
				end
			end else if (bclk_rise && cap_pkg::cap_slot_take(pos, pb_slot)) begin
				pb_sr <= {pb_sr[18:0], pin_s2[4]};
			end
		end
	end

endmodule // cap_codec_end

// *** cap_audio_ctrl.sv ***
// audio controller end: clock generation, serial port and AHB-Lite registers
`timescale 1ns/10ps
module cap_audio_ctrl (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	output logic             irq,
	cap_link_if.host         link
);

	// ********************************************
	// register bus slave
	// ********************************************
	logic [5:0]  ctrl;
	logic [19:0] tx_l;
	logic [19:0] tx_r;
	logic [19:0] rx_l;
	logic [19:0] rx_r;
	logic [1:0]  irq_st;
	logic [1:0]  irq_mask;
	logic [1:0]  irq_ev;
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic        accept;
	logic        rd_clr;
	logic [31:0] rd_val;
	logic        pdn_o;
	logic        run;

	assign accept = hsel & htrans[1] & hready;
	assign rd_clr = accept & ~hwrite & (haddr[7:0] == cap_pkg::REG_IRQ_STATUS);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = |(irq_st & irq_mask);
	assign run = ctrl[cap_pkg::CTRL_RUN];

	always_comb begin
		case (haddr[7:0])
			cap_pkg::REG_CTRL: rd_val = {26'h0, ctrl};
			cap_pkg::REG_STATUS: rd_val = {30'h0, pdn_o, run};
			cap_pkg::REG_IRQ_STATUS: rd_val = {30'h0, irq_st};
			cap_pkg::REG_IRQ_MASK: rd_val = {30'h0, irq_mask};
			cap_pkg::REG_TX_LEFT: rd_val = {12'h0, tx_l};
			cap_pkg::REG_TX_RIGHT: rd_val = {12'h0, tx_r};
			cap_pkg::REG_RX_LEFT: rd_val = {12'h0, rx_l};
			cap_pkg::REG_RX_RIGHT: rd_val = {12'h0, rx_r};
			default: rd_val = 32'h0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0;
			ctrl <= cap_pkg::CTRL_RESET;
			tx_l <= 20'h00000;
			tx_r <= 20'h00000;
			irq_mask <= 2'h0;
		end else begin
			wr_pend <= accept & hwrite;
			wr_addr <= haddr[7:0];
			if (accept && !hwrite)
				hrdata <= rd_val;
			// own registers only, no device writes
			if (wr_pend) begin
				case (wr_addr)
					cap_pkg::REG_CTRL: ctrl <= hwdata[5:0];
					cap_pkg::REG_IRQ_MASK: irq_mask <= hwdata[1:0];
					cap_pkg::REG_TX_LEFT: tx_l <= hwdata[19:0];
					cap_pkg::REG_TX_RIGHT: tx_r <= hwdata[19:0];
					default: ;
				endcase
			end
		end
	end

	// sticky events, read clears, a new event wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_st <= 2'h0;
		else
			irq_st <= (rd_clr ? 2'h0 : irq_st) | irq_ev;
	end

	// ********************************************
	// link clock generation
	// ********************************************
	logic [4:0] hdiv;
	logic [5:0] bitpos;
	logic [2:0] mdiv;
	logic [2:0] mhalf;
	logic [5:0] hp;
	logic [1:0] fmt;
	logic       left_half;
	logic       mclk_o;
	logic       bclk_o;
	logic       frame_sync_clk_o;
	logic       sdi_o;

	assign fmt = ctrl[cap_pkg::CTRL_FMT_LSB +: 2];
	assign mhalf = ctrl[cap_pkg::CTRL_MCLK384] ? cap_pkg::MCLK_HALF_384 : cap_pkg::MCLK_HALF_256;
	assign left_half = bitpos < cap_pkg::HALF_BITS;
	assign hp = left_half ? bitpos : bitpos - cap_pkg::HALF_BITS;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hdiv <= 5'h00;
			bitpos <= 6'h00;
			mdiv <= 3'h0;
			mclk_o <= 1'b0;
		end else if (!run) begin
			hdiv <= 5'h00;
			bitpos <= 6'h00;
			mdiv <= 3'h0;
			mclk_o <= 1'b0;
		end else begin
			hdiv <= hdiv + 5'h01;
			if (hdiv == 5'h1F)
				bitpos <= (bitpos == cap_pkg::FRAME_BITS - 6'h01) ? 6'h00 : bitpos + 6'h01;
			// master divides the frame evenly, stays locked
			// a rate change mid-count must not stall the master
			if (mdiv >= mhalf - 3'h1) begin
				mdiv <= 3'h0;
				mclk_o <= ~mclk_o;
			end else begin
				mdiv <= mdiv + 3'h1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bclk_o <= 1'b0;
			frame_sync_clk_o <= 1'b0;
			sdi_o <= 1'b0;
			pdn_o <= 1'b0;
		end else begin
			pdn_o <= run & ctrl[cap_pkg::CTRL_RELEASE];
			// bit clock 48fs, frame sync fs
			bclk_o <= run & (hdiv >= cap_pkg::BCLK_HALF);
			// frame sync moves only with a bit clock fall
			if (!run)
				frame_sync_clk_o <= 1'b0;
			else if (hdiv == 5'h00)
				frame_sync_clk_o <= (fmt == cap_pkg::FMT_I2S) ? ~left_half : left_half;
			if (!run)
				sdi_o <= 1'b0;
			else if (hdiv == 5'h00)
				sdi_o <= cap_pkg::cap_slot_bit(left_half ? tx_l : tx_r, hp,
					cap_pkg::cap_playback_slot(fmt, 1'b0), cap_pkg::HALF_BITS);
		end
	end

	assign link.master_clk = mclk_o;
	assign link.bit_clk = bclk_o;
	assign link.frame_sync_clk = frame_sync_clk_o;
	assign link.powerdown_n = pdn_o;
	assign link.playback_serial_in = sdi_o;

	// ********************************************
	// capture receiver
	// ********************************************
	logic [1:0]  sdo_s1;
	logic [1:0]  sdo_s2;
	logic [19:0] sr_a;
	logic [19:0] sr_b;
	cap_pkg::cap_slot_t cslot;

	assign cslot = cap_pkg::cap_capture_slot(fmt, 1'b0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sdo_s1 <= 2'h0;
			sdo_s2 <= 2'h0;
			sr_a <= 20'h00000;
			sr_b <= 20'h00000;
			rx_l <= 20'h00000;
			rx_r <= 20'h00000;
			irq_ev <= 2'h0;
		end else begin
			sdo_s1 <= {link.capture_serial_out_b, link.capture_serial_out_a};
			sdo_s2 <= sdo_s1;
			irq_ev <= 2'h0;
			if (run && hdiv == cap_pkg::BCLK_HALF) begin
				if (cap_pkg::cap_slot_take(hp, cslot)) begin
					sr_a <= {sr_a[18:0], sdo_s2[0]};
					sr_b <= {sr_b[18:0], sdo_s2[1]};
				end
				if (hp == cap_pkg::HALF_BITS - 6'h01) begin
					if (left_half) begin
						rx_l <= sr_a;
					end else begin
						rx_r <= sr_a;
						irq_ev[cap_pkg::IRQ_FRAME] <= 1'b1;
					end
					irq_ev[cap_pkg::IRQ_MISMATCH] <= sr_a != sr_b;
				end
			end
		end
	end

endmodule // cap_audio_ctrl

// *** cap_link_properties.sv ***
// assertions and covers on the serial audio link between both ends
`timescale 1ns/10ps
module cap_link_properties (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic master_clk,
	input wire logic bit_clk,
	input wire logic frame_sync_clk,
	input wire logic powerdown_n,
	input wire logic playback_serial_in,
	input wire logic capture_serial_out_a,
	input wire logic capture_serial_out_b,
	input wire logic capture_out_b_mute,
	input wire logic init_done
);
	// ********************************************
	// link checks
	// ********************************************
	logic [3:0] mclk_idle;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// cycles since the master clock last moved
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			mclk_idle <= 4'h0;
		else if ($changed(master_clk))
			mclk_idle <= 4'h0;
		else if (mclk_idle != 4'hF)
			mclk_idle <= mclk_idle + 4'h1;
	end

	AST_PDN_ZERO: assert property (!powerdown_n[*5] |-> !capture_serial_out_a)
		else $error("capture line active in powerdown");
	AST_MUTE_LOW: assert property (capture_out_b_mute[*3] |-> !capture_serial_out_b)
		else $error("muted second line not low");
	AST_B_COPY: assert property (!capture_out_b_mute[*3] |-> capture_serial_out_b == capture_serial_out_a)
		else $error("second line differs from first");
	AST_CAP_ON_FALL: assert property ($changed(capture_serial_out_a) && powerdown_n |-> !bit_clk)
		else $error("capture changed in bit clock high phase");
	AST_FS_ON_FALL: assert property ($changed(frame_sync_clk) && powerdown_n |-> !bit_clk)
		else $error("frame sync changed in bit clock high phase");
	AST_PB_ON_FALL: assert property ($changed(playback_serial_in) && powerdown_n |-> !bit_clk)
		else $error("playback changed in bit clock high phase");
	AST_INIT_ZERO: assert property (!init_done |-> !capture_serial_out_a)
		else $error("capture data before init done");
	AST_MCLK_RUNS: assert property (powerdown_n |-> mclk_idle < 4'h6)
		else $error("master clock stopped while released");

	cover property ($rose(init_done));
	cover property ($rose(powerdown_n));
	cover property (capture_out_b_mute && capture_serial_out_a);
endmodule // cap_link_properties

// *** tb_top.sv ***
// self-checking bench joining the codec end and the controller end
`timescale 1ns/10ps
module tb_top;
	// ********************************************
	// signals, ends and helpers
	// ********************************************
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, irq;
	logic [31:0] hrdata, r;
	logic [3:0]  power_manage_bits = 4'hF;
	logic [1:0]  format_select = 2'h0;
	logic        capture_out_b_mute = 1'b0;
	logic [19:0] adc_left = 20'h0;
	logic [19:0] adc_right = 20'h0;
	logic [19:0] playback_left, playback_right, tl, tr, el, er;
	logic        playback_valid, init_done, input_gain_amp_mute;
	logic        mclk_is_384, mclk_locked, bclk_is_32fs;
	logic [39:0] e;
	logic [39:0] exp_q[$];
	logic [2:0]  f;
	int          n_errors = 0;
	int          total_checks = 0;
	int          cyc = 0;

	always #12.5 hclk = ~hclk;

	cap_link_if link ();
	cap_codec_end #(.INIT_FRAMES(4)) i_cap_codec_end (.hclk, .hresetn, .link(link), .power_manage_bits,
		.format_select, .capture_out_b_mute, .adc_left, .adc_right, .playback_left, .playback_right,
		.playback_valid, .init_done, .input_gain_amp_mute, .mclk_is_384, .mclk_locked, .bclk_is_32fs);
	cap_audio_ctrl i_cap_audio_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .link(link));
	cap_link_properties i_cap_link_properties (.hclk, .hresetn, .master_clk(link.master_clk),
		.bit_clk(link.bit_clk), .frame_sync_clk(link.frame_sync_clk), .powerdown_n(link.powerdown_n),
		.playback_serial_in(link.playback_serial_in), .capture_serial_out_a(link.capture_serial_out_a),
		.capture_serial_out_b(link.capture_serial_out_b), .capture_out_b_mute, .init_done);

	task chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			n_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask

	task chb(input logic g, input logic x);
		chk({31'h0, g}, {31'h0, x});
	endtask

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task wf(input int n);
		repeat (n) @(posedge hclk iff playback_valid === 1'b1);
	endtask

	task final_report;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// scoreboard: oldest noted playback pair against received words
	always @(posedge hclk) begin
		if (playback_valid === 1'b1 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk({12'h0, playback_left}, {12'h0, e[39:20]});
			chk({12'h0, playback_right}, {12'h0, e[19:0]});
		end
	end

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			final_report;
		end
	end

	// ********************************************
	// main sequence
	// ********************************************
	initial begin
		void'($urandom(32'h8dce));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		adc_left <= 20'($urandom);
		adc_right <= 20'($urandom);
		ahb(1'h0, cap_pkg::REG_CTRL, 32'h0);
		chk(r, 32'h0);
		ahb(1'h0, 8'h40, 32'h0);
		chk(r, 32'h0);
		chb(hresp, 1'b0);
		ahb(1'h1, cap_pkg::REG_IRQ_MASK, 32'h1);
		for (f = 3'h0; f < 3'h4; f++) begin
			ahb(1'h1, cap_pkg::REG_CTRL, 32'h1);
			format_select <= f[1:0];
			tl = 20'($urandom);
			tr = 20'($urandom);
			el = (f == 3'h0) ? {tl[19:4], 4'h0} : tl;
			er = (f == 3'h0) ? {tr[19:4], 4'h0} : tr;
			ahb(1'h1, cap_pkg::REG_TX_LEFT, {12'h0, tl});
			ahb(1'h1, cap_pkg::REG_TX_RIGHT, {12'h0, tr});
			ahb(1'h1, cap_pkg::REG_CTRL, {26'h0, f[1:0], 1'h0, f[0], 2'h3});
			wf(2);
			if (f == 3'h0) begin
				chb(init_done, 1'b0);
				chb(input_gain_amp_mute, 1'b1);
				ahb(1'h0, cap_pkg::REG_RX_LEFT, 32'h0);
				chk(r, 32'h0);
			end
			wf(4);
			chb(init_done, 1'b1);
			chb(mclk_is_384, f[0]);
			chb(mclk_locked, 1'b1);
			chb(bclk_is_32fs, 1'b0);
			@(posedge hclk);
			exp_q.push_back({el, er});
			wf(1);
		end
		ahb(1'h0, cap_pkg::REG_RX_LEFT, 32'h0);
		chb(r != 32'h0, 1'b1);
		chb(irq, 1'b1);
		ahb(1'h0, cap_pkg::REG_IRQ_STATUS, 32'h0);
		chb(r[0], 1'b1);
		capture_out_b_mute <= 1'b1;
		wf(2);
		ahb(1'h0, cap_pkg::REG_IRQ_STATUS, 32'h0);
		chb(r[1], 1'b1);
		ahb(1'h1, cap_pkg::REG_IRQ_MASK, 32'h0);
		repeat (2) @(posedge hclk);
		chb(irq, 1'b0);
		power_manage_bits <= 4'h0;
		repeat (8) @(posedge hclk);
		chb(init_done, 1'b0);
		chb(input_gain_amp_mute, 1'b1);
		power_manage_bits <= 4'hF;
		ahb(1'h1, cap_pkg::REG_CTRL, 32'h1);
		repeat (8) @(posedge hclk);
		ahb(1'h0, cap_pkg::REG_STATUS, 32'h0);
		chk(r, 32'h1);
		chb(init_done, 1'b0);
		final_report;
	end
endmodule // tb_top
